/* File: src/interval_timer_pkg.sv */
// Shared constants, mode encodings and state layout of the interval timer/counter.
package interval_timer_pkg;

	// ==========================================================================
	// Widths and control word fields
	// ==========================================================================
	localparam int CTRL_WIDTH      = 16;
	localparam int COUNT_WIDTH     = 16;
	localparam int CLOCK_SOURCE_BIT = 1;
	localparam int EXT_SYNC_BIT     = 2;
	localparam int PRESCALE_LSB     = 4;
	localparam int PRESCALE_WIDTH   = 2;
	localparam int GATE_ENABLE_BIT  = 6;
	localparam int TIMER_ON_BIT     = 15;
	localparam int DIV_WIDTH        = 3;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
	localparam logic [DIV_WIDTH-1:0]   DIV_RESET   = 3'h0;
	localparam logic [1:0]             PIPE_RESET  = 2'h0;

	// ==========================================================================
	// Operating modes
	// ==========================================================================
	typedef enum logic [3:0] {
		MODE_TIMER = 4'b0001,
		MODE_GATED = 4'b0010,
		MODE_SYNC  = 4'b0100,
		MODE_ASYNC = 4'b1000
	} timer_mode_t;

	typedef struct packed {
		logic                   extMeta;
		logic                   extSync;
		logic                   extPrev;
		logic                   gateMeta;
		logic                   gateSync;
		logic [1:0]             syncPipe;
		logic [COUNT_WIDTH-1:0] count;
		logic                   periodMatch;
	} timer_state_t;

	function automatic timer_mode_t decodeMode(input logic [CTRL_WIDTH-1:0] controlWord);
		timer_mode_t mode;
		mode = MODE_TIMER;
		if (controlWord[CLOCK_SOURCE_BIT]) begin
			mode = controlWord[EXT_SYNC_BIT] ? MODE_SYNC : MODE_ASYNC;
		end else begin
			mode = controlWord[GATE_ENABLE_BIT] ? MODE_GATED : MODE_TIMER;
		end
		return mode;
	endfunction : decodeMode

endpackage : interval_timer_pkg

/* File: src/tick_prescaler.sv */
// Divides a stream of single-cycle count ticks by 1, 2, 4 or 8.
`timescale 1ns/1ns
module tick_prescaler
	import interval_timer_pkg::*;
#(
	parameter int SEL_WIDTH = PRESCALE_WIDTH,
	parameter int CNT_WIDTH = DIV_WIDTH
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 clear,
	input  wire logic                 tickIn,
	input  wire logic [SEL_WIDTH-1:0] divSelect,
	output logic                      tickOut
);

	typedef struct packed {
		logic [CNT_WIDTH-1:0] divCount;
	} prescaler_state_t;

	prescaler_state_t state;
	prescaler_state_t next_state;
	logic             atLimit;

	function automatic logic [CNT_WIDTH-1:0] prescaleLimit(input logic [SEL_WIDTH-1:0] sel);
		return CNT_WIDTH'((1 << sel) - 1);
	endfunction : prescaleLimit

	// A divider left above a newly chosen smaller limit fires at once instead of wrapping through every code.
	assign atLimit = (state.divCount >= prescaleLimit(divSelect));
	assign tickOut = tickIn && atLimit && !clear;

	always_comb begin
		next_state = state;
		if (clear) begin
			next_state.divCount = DIV_RESET;
		end else if (tickIn) begin
			next_state.divCount = atLimit ? DIV_RESET : CNT_WIDTH'(state.divCount + 1'b1);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '{divCount: DIV_RESET};
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	a_divide_by_one: assert property (@(posedge clk) disable iff (reset)
		(divSelect == 2'h0 && !clear) |-> (tickOut == tickIn))
		else $error("Prescaler at divide-by-one did not pass the tick through.");

endmodule : tick_prescaler

/* File: src/interval_timer_counter.sv */
// 16-bit interval timer/counter with timer, gated timer, synchronous and asynchronous counter modes.
//
// What this block does
// - A 16-bit counter runs freely as interval timer or event counter.
// - Timer and gated timer modes count the instruction cycle clock.
// - Both counter modes count edges of the external count clock pin.
// - Asynchronous counter mode counts external edges without post-prescaler resynchronisation.
// - Synchronous counter mode resynchronises the prescaled external tick to the clock.
// - Control bit 1 selects clock source: 0 internal, 1 external pin.
// - Control bit 2 selects external clock synchronisation.
// - Control bit 6 enables gate accumulation.
// - Internal source: gate bit picks timer or gated timer; sync bit ignored.
// - External source: sync bit picks synchronous or asynchronous; gate bit ignored.
`timescale 1ns/1ns
module interval_timer_counter
	import interval_timer_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [CTRL_WIDTH-1:0] timerControlWord,
	input  wire logic [WIDTH-1:0]      periodValue,
	input  wire logic                  extCountClockPin,
	input  wire logic                  gatePin,
	output logic [WIDTH-1:0]           timerCount,
	output logic                       periodMatch
);

	// ==========================================================================
	// State and decode
	// ==========================================================================
	timer_state_t state;
	timer_state_t next_state;
	timer_mode_t  mode;
	logic         enabled;
	logic         extEdge;
	logic         sourceTick;
	logic         prescTick;
	logic         countTick;

	assign mode    = decodeMode(timerControlWord);
	assign enabled = timerControlWord[TIMER_ON_BIT];
	assign extEdge = state.extSync && !state.extPrev;

	// ==========================================================================
	// Tick source selection
	// ==========================================================================
	always_comb begin
		case (mode)
			MODE_TIMER: begin
				sourceTick = enabled;
			end
			MODE_GATED: begin
				sourceTick = enabled && state.gateSync;
			end
			MODE_SYNC, MODE_ASYNC: begin
				sourceTick = enabled && extEdge;
			end
			default: begin
				sourceTick = 1'b0;
			end
		endcase
	end

	// Dropping the timer-on bit clears the divider, so a restart always begins a full prescale period.
	tick_prescaler #(
		.SEL_WIDTH(PRESCALE_WIDTH),
		.CNT_WIDTH(DIV_WIDTH)
	) prescaler (
		.clk      (clk),
		.reset    (reset),
		.clear    (!enabled),
		.tickIn   (sourceTick),
		.divSelect(timerControlWord[PRESCALE_LSB +: PRESCALE_WIDTH]),
		.tickOut  (prescTick)
	);

	// The synchronous mode takes its tick from the resynchronising pipe behind the prescaler.
	always_comb begin
		case (mode)
			MODE_SYNC: begin
				countTick = enabled && state.syncPipe[1];
			end
			MODE_TIMER, MODE_GATED, MODE_ASYNC: begin
				countTick = enabled && prescTick;
			end
			default: begin
				countTick = 1'b0;
			end
		endcase
	end

	// ==========================================================================
	// Next state
	// ==========================================================================
	// The count holds while disabled; only the divider is cleared, so a stopped count stays readable.
	always_comb begin
		next_state = state;
		next_state.extMeta  = extCountClockPin;
		next_state.extSync  = state.extMeta;
		next_state.extPrev  = state.extSync;
		next_state.gateMeta = gatePin;
		next_state.gateSync = state.gateMeta;
		next_state.syncPipe = {state.syncPipe[0], prescTick && (mode == MODE_SYNC)};
		next_state.periodMatch = 1'b0;
		if (countTick) begin
			if (state.count == periodValue) begin
				next_state.count       = COUNT_RESET;
				next_state.periodMatch = 1'b1;
			end else begin
				next_state.count = WIDTH'(state.count + 1'b1);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '{extMeta: 1'b0, extSync: 1'b0, extPrev: 1'b0, gateMeta: 1'b0, gateSync: 1'b0,
				syncPipe: PIPE_RESET, count: COUNT_RESET, periodMatch: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign timerCount  = state.count;
	assign periodMatch = state.periodMatch;

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// A synchronous tick reaches the counter two edges after the prescaler while the control word holds still.
	sequence s_prescTickSync;
		prescTick && enabled && (mode == MODE_SYNC);
	endsequence

	sequence s_controlHeldTwo;
		##1 $stable(timerControlWord) [*2];
	endsequence

	property p_syncAfterPrescaler;
		s_prescTickSync ##0 s_controlHeldTwo |-> countTick;
	endproperty

	a_sync_two_stage: assert property (p_syncAfterPrescaler)
		else $error("Synchronous mode tick did not reach the counter two cycles after the prescaler.");

	a_async_direct: assert property (enabled && mode == MODE_ASYNC && prescTick |-> countTick)
		else $error("Asynchronous mode tick was delayed past the prescaler.");

	a_timer_every_cycle: assert property (
		enabled && mode == MODE_TIMER && timerControlWord[PRESCALE_LSB +: PRESCALE_WIDTH] == 2'h0
		&& timerCount != periodValue && timerCount != 16'hffff
		|=> timerCount == $past(timerCount) + 16'h0001)
		else $error("Timer mode at divide-by-one did not count every cycle.");

	a_gate_hold: assert property (enabled && mode == MODE_GATED && !state.gateSync |=> $stable(timerCount))
		else $error("Gated timer changed its count while the gate was low.");

	a_counter_no_edge: assert property (
		(mode == MODE_ASYNC) && !prescTick |=> $stable(timerCount))
		else $error("Asynchronous counter changed without a prescaled external edge.");

	a_source_bit: assert property (timerControlWord[CLOCK_SOURCE_BIT]
		|-> (mode == MODE_SYNC || mode == MODE_ASYNC))
		else $error("External clock source bit did not select a counter mode.");

	a_sync_select: assert property (timerControlWord[CLOCK_SOURCE_BIT]
		|-> (mode == (timerControlWord[EXT_SYNC_BIT] ? MODE_SYNC : MODE_ASYNC)))
		else $error("Synchronisation bit did not pick the counter mode.");

	a_gate_select: assert property (!timerControlWord[CLOCK_SOURCE_BIT]
		|-> (mode == (timerControlWord[GATE_ENABLE_BIT] ? MODE_GATED : MODE_TIMER)))
		else $error("Gate enable bit did not pick the timer mode.");

	a_period_wrap: assert property (countTick && timerCount == periodValue
		|=> timerCount == COUNT_RESET && periodMatch)
		else $error("Counter did not wrap to zero with a match flag at the period.");

	a_free_increment: assert property (countTick && timerCount != periodValue
		|=> timerCount == WIDTH'($past(timerCount) + 16'h0001) && !periodMatch)
		else $error("Counter did not advance by one on a count tick.");

	// A pin edge reaches the edge detector only after both synchroniser stages.
	a_ext_two_flops: assert property ($rose(state.extSync) |-> $past(extCountClockPin, 2))
		else $error("External count clock bypassed its synchroniser.");

	a_gate_two_flops: assert property ($rose(state.gateSync) |-> $past(gatePin, 2))
		else $error("Gate input bypassed its synchroniser.");

	sequence s_gateOpenDivOne;
		enabled && mode == MODE_GATED && state.gateSync && timerControlWord[PRESCALE_LSB +: PRESCALE_WIDTH] == 2'h0;
	endsequence

	a_gate_counts: assert property (s_gateOpenDivOne ##0 timerCount != periodValue
		|=> timerCount == WIDTH'($past(timerCount) + 16'h0001))
		else $error("Gated timer did not count while the gate was open.");

	a_gate_closed_no_tick: assert property (mode == MODE_GATED && !state.gateSync |-> !prescTick)
		else $error("Gated timer produced a tick while the gate was closed.");

	// Dropping the timer-on bit freezes the count and keeps the match flag low.
	a_disabled_hold: assert property (!enabled |=> $stable(timerCount) && !periodMatch)
		else $error("Disabled timer changed its count or flagged a match.");

	a_idle_no_change: assert property (!countTick |=> $stable(timerCount) && !periodMatch)
		else $error("Counter changed without a count tick.");

	// Without a tick out of the resynchronising pipe the synchronous mode must not count.
	a_sync_needs_pipe: assert property (mode == MODE_SYNC && !state.syncPipe[1] |=> $stable(timerCount))
		else $error("Synchronous counter advanced without a resynchronised tick.");

	a_match_at_zero: assert property (periodMatch |-> timerCount == COUNT_RESET)
		else $error("Match flag stood while the count was not zero.");

	// With a nonzero period the match flag cannot stand for two cycles in a row.
	a_match_pulse: assert property (periodMatch && periodValue != COUNT_RESET |=> !periodMatch)
		else $error("Match flag stood for more than one cycle.");

endmodule : interval_timer_counter

/* File: bench/ext_signal_source.sv */
// Model of the external count clock source and gate driver.
`timescale 1ns/1ns
module ext_signal_source (
	input  wire logic clk,
	output logic      extCountClockPin,
	output logic      gatePin
);
	initial begin
		extCountClockPin = 1'b0;
		gatePin          = 1'b0;
	end

	// The count clock idles low between bursts and each pulse spans several clock periods.
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge clk);
			#1 extCountClockPin = 1'b1;
			repeat (3) @(posedge clk);
			#1 extCountClockPin = 1'b0;
		end
	endtask : pulses

	task automatic setGate(input logic level);
		@(posedge clk);
		#1 gatePin = level;
	endtask : setGate
endmodule : ext_signal_source

/* File: bench/tb_interval_timer_counter.sv */
// Self-checking testbench of the interval timer/counter.
`timescale 1ns/1ns
module tb_interval_timer_counter;
	import interval_timer_pkg::*;

	logic                  clk;
	logic                  reset;
	logic [CTRL_WIDTH-1:0] timerControlWord;
	logic [15:0]           periodValue;
	logic                  extCountClockPin;
	logic                  gatePin;
	logic [15:0]           timerCount;
	logic                  periodMatch;
	int                    num_errors;
	int                    n_compared;

	interval_timer_counter u_interval_timer_counter (.clk(clk), .reset(reset),
		.timerControlWord(timerControlWord), .periodValue(periodValue),
		.extCountClockPin(extCountClockPin), .gatePin(gatePin),
		.timerCount(timerCount), .periodMatch(periodMatch));

	ext_signal_source u_ext_signal_source (.clk(clk), .extCountClockPin(extCountClockPin), .gatePin(gatePin));

	// ==========================================================================
	// Helpers
	// ==========================================================================
	always #20 clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		n_compared++;
		if (seen !== expected) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	function automatic logic [15:0] ctl(input logic src, input logic sync, input logic gate, input logic [1:0] pre);
		logic [15:0] w;
		w = 16'h0000;
		w[TIMER_ON_BIT] = 1'b1;
		w[CLOCK_SOURCE_BIT] = src;
		w[EXT_SYNC_BIT] = sync;
		w[GATE_ENABLE_BIT] = gate;
		w[PRESCALE_LSB +: 2] = pre;
		return w;
	endfunction : ctl

	task automatic restart(input logic [15:0] word, input logic [15:0] period);
		reset = 1'b1;
		timerControlWord = 16'h0000;
		step(2);
		check(timerCount, 16'h0000);
		check({15'h0000, periodMatch}, 16'h0000);
		reset = 1'b0;
		step(1);
		timerControlWord = word;
		periodValue = period;
	endtask : restart

	task automatic close_out;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic timerWrap;
		restart(ctl(1'b0, 1'b1, 1'b0, 2'h0), 16'h0002);
		step(1);
		check(timerCount, 16'h0001);
		step(1);
		check(timerCount, 16'h0002);
		check({15'h0000, periodMatch}, 16'h0000);
		step(1);
		check(timerCount, 16'h0000);
		check({15'h0000, periodMatch}, 16'h0001);
		step(1);
		check(timerCount, 16'h0001);
		check({15'h0000, periodMatch}, 16'h0000);
		timerControlWord[TIMER_ON_BIT] = 1'b0;
		step(3);
		check(timerCount, 16'h0001);
		check({15'h0000, periodMatch}, 16'h0000);
	endtask : timerWrap

	task automatic gatedCount;
		restart(ctl(1'b0, 1'b1, 1'b1, 2'h0), 16'hffff);
		step(6);
		check(timerCount, 16'h0000);
		u_ext_signal_source.setGate(1'b1);
		step(9);
		u_ext_signal_source.setGate(1'b0);
		step(6);
		check(timerCount, 16'h000a);
		step(5);
		check(timerCount, 16'h000a);
	endtask : gatedCount

	// Rows: sync select, gate bit, prescale select, pulses sent, count expected.
	task automatic pinCounting;
		logic [4:0]  mode [4] = '{5'b0_0_00_0, 5'b1_1_01_0, 5'b0_1_11_0, 5'b1_0_10_0};
		int          sent [4] = '{5, 6, 8, 4};
		logic [15:0] want [4] = '{16'h0005, 16'h0003, 16'h0001, 16'h0001};
		for (int i = 0; i < 4; i++) begin
			restart(ctl(1'b1, mode[i][4], mode[i][3], mode[i][2:1]), 16'hffff);
			step(8);
			check(timerCount, 16'h0000);
			u_ext_signal_source.pulses(sent[i]);
			step(8);
			check(timerCount, want[i]);
		end
	endtask : pinCounting

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		timerControlWord = 16'h0000;
		periodValue = 16'hffff;
		num_errors = 0;
		n_compared = 0;
		step(12);
		reset = 1'b0;
		step(1);
		timerWrap();
		gatedCount();
		pinCounting();
		close_out();
	end

	initial begin
		#400000;
		num_errors++;
		close_out();
	end
endmodule : tb_interval_timer_counter
